/* nv_ctrl_pkg.sv */
package nv_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite slave)
    localparam logic [7:0] addr_nv_clock_ratio = 8'h00;
    localparam logic [7:0] addr_option_shadow  = 8'h04;
    localparam logic [7:0] addr_key_control    = 8'h08;
    localparam logic [7:0] addr_key_data       = 8'h0c;
    localparam logic [7:0] addr_access_status  = 8'h10;

    // ==========================================================
    // Field positions
    localparam int ratio_flag_bit     = 7;
    localparam int prescale_bit       = 6;
    localparam int ratio_msb          = 5;
    localparam int allow_bit          = 7;
    localparam int redirect_bit       = 6;
    localparam int key_select_bit     = 0;
    localparam logic [1:0] unlocked_code = 2'h2;
    localparam logic [1:0] lock_code_reset = 2'h3;

    localparam logic [7:0] option_used_mask = 8'hc3;
    localparam logic [6:0] ratio_reset      = 7'h00;

    // ==========================================================
    // Timing
    localparam int          prescale_div  = 8;
    localparam logic [2:0]  prescale_last = 3'h7;
    localparam int          key_bytes     = 8;
    localparam int          clk_mhz       = 100;
    localparam int          pulse_min_ns  = 5000;
    localparam int          pulse_max_ns  = 6700;
    localparam int          pulse_min_cyc = (pulse_min_ns * clk_mhz + 999) / 1000;
    localparam int          pulse_max_cyc = (pulse_max_ns * clk_mhz) / 1000;

    // AXI responses
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       prescale_by_eight;
        logic [5:0] ratio;
    } ratio_cfg_t;

    typedef struct packed {
        logic       backdoor_allow;
        logic       redirection_disable;
        logic [1:0] lock_state_code;
    } option_t;

    typedef struct packed {
        logic       valid;
        logic       from_secure;
        logic       write;
        logic       to_secure_target;
    } mem_access_t;

    typedef enum logic [1:0] {
        key_idle    = 2'b00,
        key_collect = 2'b01,
        key_compare = 2'b10
    } key_state_t;

endpackage

/* nv_timing_divider.sv */
`timescale 1ns/1ps
module nv_timing_divider
    import nv_ctrl_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  ratio_cfg_t      cfg,
    output logic            timing_pulse
);
    logic [2:0] pre_count;
    logic [5:0] main_count;
    logic       pre_tick;

    // ==========================================================
    // Prescaler and reload counter
    assign pre_tick = cfg.prescale_by_eight ? (pre_count == prescale_last) : 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            pre_count <= 3'h0;
        end else begin
            pre_count <= pre_count + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            main_count   <= 6'h00;
            timing_pulse <= 1'b0;
        end else if (pre_tick) begin
            // Period is ratio+1 selected ticks
            if (main_count >= cfg.ratio) begin
                main_count   <= 6'h00;
                timing_pulse <= 1'b1;
            end else begin
                main_count   <= main_count + 6'h01;
                timing_pulse <= 1'b0;
            end
        end else begin
            timing_pulse <= 1'b0;
        end
    end
endmodule // nv_timing_divider

/* nv_key_compare.sv */
`timescale 1ns/1ps
module nv_key_compare
    import nv_ctrl_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                key_select,
    input  wire logic                byte_write,
    input  wire logic [7:0]          byte_data,
    input  wire logic [8*key_bytes-1:0] stored_unlock_bytes,
    output logic                     key_match
);
    key_state_t  state;
    logic [3:0]  count;
    logic        all_equal;

    // ==========================================================
    // Collect eight bytes in ascending order, compare on deselect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= key_idle;
            count     <= 4'h0;
            all_equal <= 1'b1;
            key_match <= 1'b0;
        end else begin
            key_match <= 1'b0;
            case (state)
                key_idle: begin
                    count     <= 4'h0;
                    all_equal <= 1'b1;
                    if (key_select) state <= key_collect;
                end
                key_collect: begin
                    if (byte_write && count < 4'(key_bytes)) begin
                        count <= count + 4'h1;
                        if (byte_data != stored_unlock_bytes[count[2:0]*8 +: 8])
                            all_equal <= 1'b0;
                    end
                    if (!key_select) state <= key_compare;
                end
                key_compare: begin
                    key_match <= all_equal && (count == 4'(key_bytes));
                    state     <= key_idle;
                end
                default: state <= key_idle;
            endcase
        end
    end
endmodule // nv_key_compare

/* nv_clock_options.sv */
`timescale 1ns/1ps
module nv_clock_options
    import nv_ctrl_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Nonvolatile contents, static while the part runs
    input  wire logic [7:0]             stored_option_byte,
    input  wire logic [8*key_bytes-1:0] stored_unlock_bytes,
    // Events from the command engine
    input  wire logic                   blank_check_pass,
    input  wire logic                   key_write_secure,
    input  wire logic [7:0]             key_write_data,
    // Memory access screening
    input  mem_access_t                 access_req,
    input  wire logic [7:0]             access_rdata,
    // Outputs
    output logic                        program_erase_enable,
    output logic                        timing_pulse,
    output logic                        key_write_to_key,
    output logic                        redirection_enable,
    output logic                        part_locked,
    output logic [1:0]                  lock_state_code,
    output logic                        access_grant,
    output logic [7:0]                  access_rdata_out
);

    // ==========================================================
    // State
    logic       ratio_written_flag;
    ratio_cfg_t ratio_cfg;
    option_t    option_shadow;
    logic       load_done;
    logic       key_entry_select;
    logic       unlocked_by_event;
    logic       key_match;
    logic       divider_pulse;
    logic       blocked_count;

    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       do_write;
    logic       do_read;

    function automatic logic is_unlocked(input logic [1:0] code);
        return code == unlocked_code;
    endfunction

    // Unsecured source aiming at secure memory while the part is locked
    function automatic logic is_blocked(input mem_access_t req, input logic locked);
        return req.valid && locked && req.to_secure_target && !req.from_secure;
    endfunction

    // Register write decode, shared by every writable register
    function automatic logic write_hits(input logic       go,
                                        input logic [7:0] at,
                                        input logic [3:0] strb,
                                        input logic [7:0] target);
        return go && (at == target) && strb[0];
    endfunction

    // ==========================================================
    // AXI write path: address and data taken in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Address channel: one beat, held until the response is raised
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            // Ready pulses for one cycle so a held beat is never taken twice
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            if (do_write) begin
                aw_held <= 1'b0;
            end else if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
        end
    end

    // Data channel, independent of the address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (do_write) begin
                w_held <= 1'b0;
            end else if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Response: raised once both beats are held, kept until bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                addr_nv_clock_ratio,
                addr_option_shadow,
                addr_key_control,
                addr_key_data,
                addr_access_status: s_axi_bresp <= resp_okay;
                default:            s_axi_bresp <= resp_slverr;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Ratio register: one write after reset only
    // Later writes get OKAY and change nothing; a stray store cannot retime erase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ratio_written_flag <= 1'b0;
            ratio_cfg          <= ratio_reset;
        end else if (write_hits(do_write, aw_addr, w_strb, addr_nv_clock_ratio)
                     && !ratio_written_flag) begin
            ratio_written_flag <= 1'b1;
            ratio_cfg          <= w_data[prescale_bit:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_erase_enable <= 1'b0;
        end else begin
            program_erase_enable <= ratio_written_flag;
        end
    end

    // Divider held cleared until the ratio is written, so no pulse runs unset
    nv_timing_divider u_divider (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (ratio_written_flag),
        .cfg          (ratio_cfg),
        .timing_pulse (divider_pulse)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timing_pulse <= 1'b0;
        end else begin
            timing_pulse <= divider_pulse;
        end
    end

    // ==========================================================
    // Option shadow: captured on the first clock after reset release
    // Nothing else writes the shadow; a new option needs a new reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_done     <= 1'b0;
            option_shadow <= '0;
        end else if (!load_done) begin
            load_done     <= 1'b1;
            option_shadow <= {stored_option_byte[allow_bit],
                              stored_option_byte[redirect_bit],
                              stored_option_byte[1:0]};
        end
    end

    // ==========================================================
    // Key entry
    // Select is kept as written; the comparator sees it only with backdoor use allowed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_entry_select <= 1'b0;
        end else if (write_hits(do_write, aw_addr, w_strb, addr_key_control)) begin
            key_entry_select <= w_data[key_select_bit];
        end
    end

    // Only secure-code writes reach the comparator; debug writes never do
    nv_key_compare u_key (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .key_select          (key_entry_select && option_shadow.backdoor_allow),
        .byte_write          (key_write_secure),
        .byte_data           (key_write_data),
        .stored_unlock_bytes (stored_unlock_bytes),
        .key_match           (key_match)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_write_to_key <= 1'b0;
        end else begin
            key_write_to_key <= key_entry_select;
        end
    end

    // Sticky until the next reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlocked_by_event <= 1'b0;
        end else if ((key_match && option_shadow.backdoor_allow) || blank_check_pass) begin
            unlocked_by_event <= 1'b1;
        end
    end

    // ==========================================================
    // Lock state and redirection outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Locked from reset on; an unloaded shadow code also reads as locked
            lock_state_code    <= lock_code_reset;
            part_locked        <= 1'b1;
            redirection_enable <= 1'b0;
        end else begin
            lock_state_code    <= unlocked_by_event ? unlocked_code
                                                    : option_shadow.lock_state_code;
            part_locked        <= !(unlocked_by_event
                                    || is_unlocked(option_shadow.lock_state_code));
            redirection_enable <= load_done && !option_shadow.redirection_disable;
        end
    end

    // ==========================================================
    // Access screening: one cycle latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            access_grant     <= 1'b0;
            access_rdata_out <= 8'h00;
        end else begin
            access_grant     <= access_req.valid
                                && !is_blocked(access_req, part_locked);
            if (is_blocked(access_req, part_locked)) begin
                // Blocked reads see zeros; blocked writes never get a grant
                access_rdata_out <= 8'h00;
            end else begin
                access_rdata_out <= access_rdata;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blocked_count <= 1'b0;
        end else if (is_blocked(access_req, part_locked)) begin
            // Sticky record that some access was refused
            blocked_count <= 1'b1;
        end
    end

    // ==========================================================
    // AXI read path
    assign do_read = s_axi_arvalid && s_axi_arready;

    // One address beat per read; ready stays low until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= resp_okay;
        end else begin
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= resp_okay;
                case (s_axi_araddr)
                    addr_nv_clock_ratio:
                        s_axi_rdata <= {24'h000000, ratio_written_flag, ratio_cfg};
                    addr_option_shadow:
                        s_axi_rdata <= {24'h000000, option_shadow.backdoor_allow,
                                        option_shadow.redirection_disable, 4'h0,
                                        lock_state_code};
                    addr_key_control:
                        s_axi_rdata <= {31'h00000000, key_entry_select};
                    addr_key_data:
                        s_axi_rdata <= 32'h0000_0000;
                    addr_access_status:
                        s_axi_rdata <= {30'h00000000, blocked_count, part_locked};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= resp_slverr;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // nv_clock_options

/* nv_clock_options_monitor.sv */
`timescale 1ns/1ps
module nv_clock_options_monitor
    import nv_ctrl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  mem_access_t      access_req,
    input  wire logic [7:0]  access_rdata,
    input  wire logic        program_erase_enable,
    input  wire logic        part_locked,
    input  wire logic [1:0]  lock_state_code,
    input  wire logic        access_grant,
    input  wire logic [7:0]  access_rdata_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Register bus
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write response did not arrive");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
        |=> s_axi_rvalid && s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    // ==========================================================
    // Divider and lock state
    a_enable_sticky: assert property (program_erase_enable |=> program_erase_enable)
        else $error("program enable fell without reset");
    a_lock_decode: assert property (part_locked == (lock_state_code != unlocked_code))
        else $error("lock flag disagrees with lock code");
    a_unlock_sticky: assert property (!part_locked |=> !part_locked)
        else $error("part relocked without reset");

    // ==========================================================
    // Access screening
    a_blocked_access: assert property (access_req.valid && part_locked &&
        access_req.to_secure_target && !access_req.from_secure
        |=> !access_grant && access_rdata_out == 8'h00) else $error("blocked access leaked");
    a_secure_access: assert property (access_req.valid && access_req.from_secure
        |=> access_grant && access_rdata_out == $past(access_rdata))
        else $error("secure access not granted");
endmodule // nv_clock_options_monitor

bind nv_clock_options nv_clock_options_monitor nv_clock_options_monitor_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .access_req, .access_rdata, .program_erase_enable, .part_locked, .lock_state_code,
    .access_grant, .access_rdata_out);

/* flash_clock_divider_options_bench.sv */
`timescale 1ns/1ps
module flash_clock_divider_options_bench;
    import nv_ctrl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, lock_state_code;
    logic [7:0] stored_option_byte = 8'h83, key_write_data = 8'h00;
    logic [7:0] access_rdata = 8'h00, access_rdata_out;
    logic [63:0] stored_unlock_bytes = 64'h0123_4567_89ab_cdef;
    logic blank_check_pass = 1'b0, key_write_secure = 1'b0;
    mem_access_t access_req = '0;
    logic program_erase_enable, timing_pulse, key_write_to_key, redirection_enable;
    logic part_locked, access_grant;
    int n_fail = 0, comparisons = 0;
    logic [7:0] opts [4] = '{8'h40, 8'h01, 8'hc2, 8'h83};

    nv_clock_options nv_clock_options_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .stored_option_byte, .stored_unlock_bytes, .blank_check_pass, .key_write_secure,
        .key_write_data, .access_req, .access_rdata, .program_erase_enable, .timing_pulse,
        .key_write_to_key, .redirection_enable, .part_locked, .lock_state_code,
        .access_grant, .access_rdata_out);

    always #5 aclk = ~aclk;

    // ==========================================================
    // Helpers
    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reset_dut(input logic [7:0] opt);
        aresetn <= 1'b0;
        stored_option_byte <= opt;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        // Late bready exercises the response hold
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, e);
        check(s_axi_rresp, er);
        @(posedge aclk);
    endtask

    task automatic pulse_period(input int exp);
        int n;
        n = 0;
        do @(posedge aclk); while (!timing_pulse);
        do begin
            @(posedge aclk);
            n++;
        end while (!timing_pulse);
        check(n, exp);
        if (exp >= pulse_min_cyc)
            check(n >= pulse_min_cyc && n <= pulse_max_cyc, 1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic check_options(input logic [7:0] opt);
        reset_dut(opt);
        check(program_erase_enable, 0);
        check(part_locked, opt[1:0] != unlocked_code);
        check(lock_state_code, opt[1:0]);
        check(redirection_enable, !opt[6]);
        rd(addr_option_shadow, opt & option_used_mask, resp_okay);
        rd(addr_nv_clock_ratio, 32'h0, resp_okay);
    endtask

    task automatic ratio_once;
        // Prescaled 100 MHz over 64 gives a 195 kHz timing clock
        wr(addr_nv_clock_ratio, 32'hffff_ff7f, resp_okay);
        rd(addr_nv_clock_ratio, 32'h0000_00ff, resp_okay);
        check(program_erase_enable, 1);
        wr(addr_nv_clock_ratio, 32'h0000_0005, resp_okay);
        rd(addr_nv_clock_ratio, 32'h0000_00ff, resp_okay);
        pulse_period(512);
        rd(8'h20, 32'h0, resp_slverr);
        wr(8'h20, 32'h1, resp_slverr);
    endtask

    task automatic access(input logic sec, input logic exp);
        access_req <= {1'b1, sec, 1'b0, 1'b1};
        access_rdata <= 8'h5a;
        @(posedge aclk);
        #1;
        check(access_grant, exp);
        check(access_rdata_out, exp ? 8'h5a : 8'h00);
        @(posedge aclk);
        access_req <= '0;
        @(posedge aclk);
    endtask

    task automatic key_try(input logic [63:0] k, input logic allow);
        wr(addr_key_control, 32'h1, resp_okay);
        rd(addr_key_control, 32'h0000_0001, resp_okay);
        @(posedge aclk);
        if (allow) check(key_write_to_key, 1);
        for (int i = 0; i < key_bytes; i++) begin
            key_write_secure <= 1'b1;
            key_write_data <= k[8*i +: 8];
            @(posedge aclk);
            key_write_secure <= 1'b0;
            @(posedge aclk);
        end
        wr(addr_key_control, 32'h0, resp_okay);
        repeat (4) @(posedge aclk);
    endtask

    task automatic blank_unlock;
        blank_check_pass <= 1'b1;
        @(posedge aclk);
        blank_check_pass <= 1'b0;
        repeat (3) @(posedge aclk);
        check(part_locked, 0);
        check(lock_state_code, unlocked_code);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        foreach (opts[i]) check_options(opts[i]);
        ratio_once();
        access(1'b0, 1'b0);
        rd(addr_access_status, 32'h0000_0003, resp_okay);
        access(1'b1, 1'b1);
        key_try(64'hefcd_ab89_6745_2301, 1'b1);
        check(part_locked, 1);
        key_try(stored_unlock_bytes, 1'b1);
        check(part_locked, 0);
        check(lock_state_code, unlocked_code);
        rd(addr_option_shadow, 32'h0000_0082, resp_okay);
        access(1'b0, 1'b1);
        check_options(8'h40);
        key_try(stored_unlock_bytes, 1'b0);
        check(part_locked, 1);
        blank_unlock();
        wr(addr_nv_clock_ratio, 32'h0000_0005, resp_okay);
        pulse_period(6);
        complete_run();
    end

    // Whole run needs about 1300 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run();
    end
endmodule // flash_clock_divider_options_bench
